// ==== design/descriptor_pool.sv ====
`timescale 1ns/1ps
module descriptor_pool #(
    parameter int DEPTH = dma_pkg::NUM_DESCRIPTORS
) (
    // Clock
    input  wire logic                                clk,
    // Software write port
    input  wire logic                                wr_en,
    input  wire logic [dma_pkg::DESC_W-1:0]          wr_index,
    input  wire dma_pkg::transfer_descriptor_t       wr_data,
    // Controller read port
    input  wire logic [dma_pkg::DESC_W-1:0]          rd_index,
    output dma_pkg::transfer_descriptor_t            rd_data
);

    // Writes are accepted at any time, so a later load sees the update.
    dma_pkg::transfer_descriptor_t mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data; // see [RL14]
        end
        rd_data <= mem[rd_index];
    end

endmodule

// ==== design/dma_controller.sv ====
// Overview of operation
// [RL1] Twenty-four channels draw descriptors from one pool of 128.
// [RL2] Eight priority levels per channel; lower number wins arbitration.
// [RL3] CPU always takes the bus first, yet the controller is never starved.
// [RL4] Higher priority preempts only at a finished bus transaction.
// [RL5] Fairness guarantees levels 2 to 7 halving shares of bandwidth.
// [RL6] Levels 0 and 1 skip fairness and may take all bandwidth.
// [RL7] Equal-level requesters share grants round robin.
// [RL8] A per-channel bit puts a channel at the head of its level.
// [RL9] Without fairness, grants follow priority level strictly.
// [RL10] Transfers start from a routed trigger, software, or another channel's end.
// [RL11] Each channel raises up to two interrupts per transfer.
// [RL12] Active channels may be stalled or cancelled.
// [RL13] Lengths run 1 byte to 64 KB, or unbounded until stopped.
// [RL14] Descriptors stay writable; updates apply on next load.
// [RL15] Each descriptor may name a next descriptor to chain.
// [RL16] A self-linked descriptor repeats forever.
// [RL17] Two mutually linked descriptors alternate for double buffering.
// [RL18] A ring of descriptors returns to its first after the last.
// [RL19] Each chained descriptor carries its own source and destination.
// [RL20] CPU and controller are both hub masters.
// [RL21] Source and destination bursts may overlap on different spokes.
// [RL22] Accesses support 8, 16, 24 and 32 bit widths.
// [RL23] After reset channels idle, round robin pointers at lowest channel.
// [RL24] Completion is signalled before the chained successor is fetched.
`timescale 1ns/1ps
module dma_controller #(
    parameter int N = dma_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    // Descriptor write port from software
    input  wire logic                                  desc_wr_en,
    input  wire logic [dma_pkg::DESC_W-1:0]            desc_wr_index,
    input  wire dma_pkg::transfer_descriptor_t         desc_wr_data,
    // Channel configuration
    input  wire logic [N-1:0]                          ch_enable,
    input  wire logic [N-1:0][dma_pkg::DESC_W-1:0]     ch_first_desc,
    input  wire logic [N-1:0][2:0]                     ch_level,
    input  wire logic [N-1:0]                          ch_no_rotate,
    input  wire logic [N-1:0]                          ch_irq_on_start,
    input  wire logic [N-1:0][dma_pkg::CH_W-1:0]       ch_trig_src,
    input  wire logic [N-1:0]                          ch_trig_by_chan,
    input  wire logic                                  fair_en,
    // Triggers and control
    input  wire logic [N-1:0]                          hw_trig,
    input  wire logic [N-1:0]                          sw_trig,
    input  wire logic [N-1:0]                          ch_stall,
    input  wire logic [N-1:0]                          ch_cancel,
    // Shared bus with the CPU
    input  wire logic                                  cpu_req,
    input  wire logic                                  bus_done,
    output dma_pkg::bus_req_t                          bus_req,
    // Status
    output logic [N-1:0]                               ch_busy,
    output logic [N-1:0]                               ch_desc_done,
    output logic [N-1:0]                               ch_irq_start,
    output logic [N-1:0]                               ch_irq_done
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        dma_pkg::ch_state_t [N-1:0]                        st;
        logic [N-1:0][dma_pkg::DESC_W-1:0]                 cur;
        logic [N-1:0][dma_pkg::LEN_W-1:0]                  left;
        logic [N-1:0][dma_pkg::ADDR_W-1:0]                 src;
        logic [N-1:0][dma_pkg::ADDR_W-1:0]                 dst;
        logic [N-1:0][1:0]                                 width;
        logic [N-1:0]                                      unbounded;
        logic [N-1:0]                                      nxt_valid;
        logic [N-1:0]                                      irq_en;
        logic [N-1:0]                                      pending;
        logic                                              loading;
        logic [dma_pkg::CH_W-1:0]                          load_ch;
        logic                                              load_wait;
        logic                                              in_flight;
        logic                                              cpu_wait;
        dma_pkg::bus_req_t                                 bus;
        logic [N-1:0]                                      busy;
        logic [N-1:0]                                      desc_done;
        logic [N-1:0]                                      irq_start;
        logic [N-1:0]                                      irq_done;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    dma_pkg::transfer_descriptor_t rd_data;
    logic [dma_pkg::DESC_W-1:0]    rd_index;
    logic [N-1:0]                  arb_req;
    logic [N-1:0]                  ch_loading;
    logic                          arb_found;
    logic [dma_pkg::CH_W-1:0]      arb_winner;
    logic                          arb_advance;
    logic [N-1:0]                  hw_trig_m;
    logic [N-1:0]                  hw_trig_s;

    // Bytes moved by one access of the given width code.
    function automatic logic [dma_pkg::LEN_W-1:0] step_bytes(input logic [1:0] w);
        return dma_pkg::LEN_W'(w) + 17'h00001; // see [RL22]
    endfunction

    // ********************************************************************
    // Submodules
    // ********************************************************************
    descriptor_pool #(
        .DEPTH(dma_pkg::NUM_DESCRIPTORS)
    ) u_pool (
        .clk      (clk),
        .wr_en    (desc_wr_en),
        .wr_index (desc_wr_index),
        .wr_data  (desc_wr_data),
        .rd_index (rd_index),
        .rd_data  (rd_data)
    ); // see [RL1]

    priority_arbiter #(
        .N(N)
    ) u_arb (
        .clk       (clk),
        .reset     (reset),
        .req       (arb_req),
        .level     (ch_level),
        .no_rotate (ch_no_rotate),
        .fair_en   (fair_en),
        .advance   (arb_advance),
        .found     (arb_found),
        .winner    (arb_winner)
    );

    // Routed triggers come from outside this clock domain.
    always_ff @(posedge clk) begin
        hw_trig_m <= hw_trig;
        hw_trig_s <= hw_trig_m;
    end

    assign rd_index = s_q.cur[s_q.load_ch];

    always_comb begin
        for (int c = 0; c < N; c++) begin
            arb_req[c] = (s_q.st[c] == dma_pkg::CH_RUN) && !ch_stall[c] && !ch_cancel[c];
            ch_loading[c] = (s_q.st[c] == dma_pkg::CH_LOAD);
        end
    end

    // A new grant is only taken between transactions, never mid-access.
    assign arb_advance = !s_q.in_flight && !s_q.loading && (!cpu_req || s_q.cpu_wait) && !(|ch_loading); // see [RL4]

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        logic [N-1:0] trig;
        logic [dma_pkg::CH_W-1:0] g;
        logic [dma_pkg::LEN_W-1:0] step;
        trig = '0;
        g = '0;
        step = '0;
        s_d = s_q;
        s_d.desc_done = '0;
        s_d.irq_start = '0;
        s_d.irq_done = '0;
        for (int c = 0; c < N; c++) begin
            trig[c] = hw_trig_s[c] || sw_trig[c] ||
                      (ch_trig_by_chan[c] && s_q.desc_done[ch_trig_src[c]]); // see [RL10]
            if (ch_enable[c] && trig[c]) begin
                s_d.pending[c] = 1'b1;
            end
            if (ch_cancel[c] || !ch_enable[c]) begin
                s_d.pending[c] = 1'b0;
                if (!(s_q.in_flight && s_q.bus.channel == dma_pkg::CH_W'(c)) &&
                    !(s_q.loading && s_q.load_ch == dma_pkg::CH_W'(c))) begin
                    s_d.st[c] = dma_pkg::CH_IDLE; // see [RL12]
                end
            end else if (s_q.st[c] == dma_pkg::CH_IDLE && s_q.pending[c]) begin
                s_d.pending[c] = trig[c];
                s_d.cur[c] = ch_first_desc[c];
                s_d.st[c] = dma_pkg::CH_LOAD;
            end
        end
        // One descriptor load at a time through the single pool read port.
        if (!s_q.loading) begin
            for (int c = N - 1; c >= 0; c--) begin
                if (s_d.st[c] == dma_pkg::CH_LOAD && !(s_q.in_flight && s_q.bus.channel == dma_pkg::CH_W'(c))) begin
                    s_d.loading = 1'b1;
                    s_d.load_ch = dma_pkg::CH_W'(c);
                    s_d.load_wait = 1'b1;
                end
            end
        end else if (s_q.load_wait) begin
            s_d.load_wait = 1'b0;
        end else begin
            s_d.loading = 1'b0;
            s_d.src[s_q.load_ch] = rd_data.src_addr; // see [RL19]
            s_d.dst[s_q.load_ch] = rd_data.dst_addr;
            s_d.width[s_q.load_ch] = rd_data.width;
            s_d.left[s_q.load_ch] = rd_data.length;
            s_d.unbounded[s_q.load_ch] = (rd_data.length == dma_pkg::LEN_UNBOUNDED); // see [RL13]
            s_d.cur[s_q.load_ch] = rd_data.next_desc;
            s_d.nxt_valid[s_q.load_ch] = rd_data.has_next;
            s_d.irq_en[s_q.load_ch] = rd_data.irq_on_done;
            if (s_q.st[s_q.load_ch] == dma_pkg::CH_LOAD) begin
                s_d.st[s_q.load_ch] = dma_pkg::CH_RUN;
                s_d.irq_start[s_q.load_ch] = ch_irq_on_start[s_q.load_ch]; // see [RL11]
            end
        end
        // The CPU takes the bus first when it asks; while it keeps asking, every second cycle is left for us.
        s_d.cpu_wait = cpu_req && !s_q.cpu_wait; // see [RL3] [RL20]
        if (s_q.in_flight) begin
            if (bus_done) begin
                g = s_q.bus.channel;
                s_d.in_flight = 1'b0;
                s_d.bus.valid = 1'b0;
                step = step_bytes(s_q.width[g]);
                s_d.src[g] = s_q.src[g] + dma_pkg::ADDR_W'(step);
                s_d.dst[g] = s_q.dst[g] + dma_pkg::ADDR_W'(step);
                if (!s_q.unbounded[g]) begin
                    if (s_q.left[g] <= step) begin
                        s_d.left[g] = '0;
                        s_d.desc_done[g] = 1'b1; // see [RL24]
                        s_d.irq_done[g] = s_q.irq_en[g]; // see [RL11]
                        if (s_q.nxt_valid[g]) begin
                            s_d.st[g] = dma_pkg::CH_LOAD; // see [RL15] [RL16] [RL17] [RL18]
                        end else begin
                            s_d.st[g] = dma_pkg::CH_IDLE;
                        end
                    end else begin
                        s_d.left[g] = s_q.left[g] - step;
                    end
                end
            end
        end else if (arb_advance && arb_found) begin
            s_d.in_flight = 1'b1;
            s_d.bus.valid = 1'b1; // see [RL21]
            s_d.bus.channel = arb_winner;
            s_d.bus.src_addr = s_q.src[arb_winner];
            s_d.bus.dst_addr = s_q.dst[arb_winner];
            s_d.bus.width = s_q.width[arb_winner];
        end
        for (int c = 0; c < N; c++) begin
            s_d.busy[c] = (s_d.st[c] != dma_pkg::CH_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0; // see [RL23]
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_req = s_q.bus;
    assign ch_busy = s_q.busy;
    assign ch_desc_done = s_q.desc_done;
    assign ch_irq_start = s_q.irq_start;
    assign ch_irq_done = s_q.irq_done;

endmodule

// ==== design/dma_pkg.sv ====
package dma_pkg;

    // ********************************************************************
    // Sizes
    // ********************************************************************
    localparam int NUM_CHANNELS = 24;
    localparam int NUM_DESCRIPTORS = 128;
    localparam int NUM_LEVELS = 8;
    localparam int CH_W = 5;
    localparam int DESC_W = 7;
    localparam int LEVEL_W = 3;
    localparam int LEN_W = 17;
    localparam int ADDR_W = 32;

    // ********************************************************************
    // Field values and reset values
    // ********************************************************************
    localparam logic [LEN_W-1:0] MAX_LEN = 17'h10000;
    localparam logic [LEN_W-1:0] LEN_UNBOUNDED = 17'h00000;
    localparam logic [LEVEL_W-1:0] FAIR_FIRST_LEVEL = 3'h2;
    localparam logic [CH_W-1:0] RR_PTR_RESET = 5'h00;
    localparam logic [7:0] FAIR_CNT_RESET = 8'h00;

    // Access width codes: 0 = 8, 1 = 16, 2 = 24, 3 = 32 bits.
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_32 = 2'h3;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] src_addr;
        logic [ADDR_W-1:0] dst_addr;
        logic [LEN_W-1:0]  length;
        logic [1:0]        width;
        logic [DESC_W-1:0] next_desc;
        logic              has_next;
        logic              irq_on_done;
    } transfer_descriptor_t;

    typedef struct packed {
        logic                    valid;
        logic [CH_W-1:0]         channel;
        logic [ADDR_W-1:0]       src_addr;
        logic [ADDR_W-1:0]       dst_addr;
        logic [1:0]              width;
    } bus_req_t;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_LOAD,
        CH_RUN
    } ch_state_t;

endpackage

// ==== design/priority_arbiter.sv ====
`timescale 1ns/1ps
module priority_arbiter #(
    parameter int N = dma_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Requests
    input  wire logic [N-1:0]                  req,
    input  wire logic [N-1:0][2:0]             level,
    input  wire logic [N-1:0]                  no_rotate,
    input  wire logic                          fair_en,
    input  wire logic                          advance,
    // Result
    output logic                               found,
    output logic [dma_pkg::CH_W-1:0]           winner
);

    typedef struct packed {
        logic [7:0][dma_pkg::CH_W-1:0] rr_ptr;
        logic [7:0]                    fair_cnt;
    } arb_state_t;

    arb_state_t s_q;
    arb_state_t s_d;
    logic [2:0] win_level;

    function automatic logic [dma_pkg::CH_W-1:0] ch_idx(input int i);
        return dma_pkg::CH_W'(i);
    endfunction

    // Picks a channel at one level, head-of-line first, then rotation.
    function automatic logic [dma_pkg::CH_W:0] pick(input logic [N-1:0] r,
            input logic [N-1:0] nr, input logic [dma_pkg::CH_W-1:0] ptr);
        logic [dma_pkg::CH_W:0] res;
        int k;
        res = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (r[i] && nr[i]) begin
                res = {1'b1, ch_idx(i)}; // see [RL8]
            end
        end
        if (!res[dma_pkg::CH_W]) begin
            for (int i = N - 1; i >= 0; i--) begin
                k = (int'(ptr) + i) % N;
                if (r[k]) begin
                    res = {1'b1, ch_idx(k)}; // see [RL7]
                end
            end
        end
        return res;
    endfunction

    always_comb begin
        logic [7:0][N-1:0] lvl_req;
        logic [7:0] any;
        logic [dma_pkg::CH_W:0] p;
        logic [2:0] strict_lvl;
        logic [2:0] fair_lvl;
        logic got_fair;
        lvl_req = '0;
        any = '0;
        p = '0;
        strict_lvl = '0;
        fair_lvl = '0;
        got_fair = 1'b0;
        s_d = s_q;
        for (int c = 0; c < N; c++) begin
            lvl_req[level[c]][c] = req[c];
        end
        for (int l = 0; l < 8; l++) begin
            any[l] = |lvl_req[l];
        end
        for (int l = 7; l >= 0; l--) begin
            if (any[l]) begin
                strict_lvl = 3'(l); // see [RL2] [RL9]
            end
        end
        // A counter stepped on each grant gives level L a slot in 1 of 2^(L-1) grants.
        for (int l = 7; l >= 2; l--) begin
            if (any[l] && (s_q.fair_cnt & ((8'h01 << (l - 1)) - 8'h01)) == ((8'h01 << (l - 2)) - 8'h01)) begin
                fair_lvl = 3'(l);
                got_fair = 1'b1;
            end
        end
        win_level = strict_lvl;
        if (fair_en && !any[0] && !any[1] && got_fair) begin
            win_level = fair_lvl; // see [RL5] [RL6]
        end
        p = pick(lvl_req[win_level], no_rotate, s_q.rr_ptr[win_level]);
        found = p[dma_pkg::CH_W];
        winner = p[dma_pkg::CH_W-1:0];
        if (advance && found) begin
            s_d.fair_cnt = s_q.fair_cnt + 8'h01;
            s_d.rr_ptr[win_level] = (winner == ch_idx(N - 1)) ? '0 : winner + 1'b1; // see [RL7]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{rr_ptr: '0, fair_cnt: dma_pkg::FAIR_CNT_RESET}; // see [RL23]
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ==== verif/dma_monitor.sv ====
`timescale 1ns/1ps
module dma_monitor #(
    parameter int N = dma_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Watched ports
    input wire logic [N-1:0]      ch_enable,
    input wire logic [N-1:0]      ch_cancel,
    input wire logic              bus_done,
    input wire dma_pkg::bus_req_t bus_req,
    input wire logic [N-1:0]      ch_busy,
    input wire logic [N-1:0]      ch_desc_done,
    input wire logic [N-1:0]      ch_irq_start,
    input wire logic [N-1:0]      ch_irq_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_idle: assert property ($fell(reset) |-> ch_busy == '0 && !bus_req.valid)
        else $error("channel active right after reset");
    a_no_switch: assert property (bus_req.valid && !bus_done ##1 bus_req.valid
        |-> $stable(bus_req.channel) && $stable(bus_req.src_addr)) else $error("request changed mid transaction");
    a_grant_busy: assert property (bus_req.valid |-> ch_busy[bus_req.channel])
        else $error("request from an idle channel");
    a_chan_range: assert property (bus_req.valid |-> bus_req.channel < N)
        else $error("request from a channel out of range");
    a_start_enabled: assert property ((ch_busy & ~$past(ch_busy) & ~$past(ch_enable)) == '0)
        else $error("disabled channel started");
    a_done_busy: assert property (|ch_desc_done |-> (ch_desc_done & ~(ch_busy | $past(ch_busy))) == '0)
        else $error("completion from an idle channel");
    a_irq_busy: assert property (((ch_irq_start | ch_irq_done) & ~(ch_busy | $past(ch_busy))) == '0)
        else $error("interrupt from an idle channel");
    for (genvar c = 0; c < N; c++) begin : g_ch
        a_cancel_stops: assert property ($rose(ch_cancel[c]) |-> ##[1:64] !ch_busy[c])
            else $error("channel still busy after cancel");
    end
endmodule

bind dma_controller dma_monitor #(.N(N)) u_mon (.clk, .reset, .ch_enable, .ch_cancel, .bus_done, .bus_req,
    .ch_busy, .ch_desc_done, .ch_irq_start, .ch_irq_done);

// ==== verif/hub_model.sv ====
`timescale 1ns/1ps
module hub_model (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Controller side
    input wire dma_pkg::bus_req_t bus_req,
    output logic                  bus_done,
    // CPU side and pacing
    input wire logic              cpu_want,
    input wire logic [3:0]        wait_cycles,
    output logic                  cpu_req
);
    logic [3:0] wait_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            bus_done <= 1'b0;
            cpu_req <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            cpu_req <= cpu_want;
            bus_done <= 1'b0;
            if (!bus_req.valid || bus_done) begin
                wait_q <= 4'h0;
            end else if (!cpu_req && wait_q >= wait_cycles) begin
                bus_done <= 1'b1;
                wait_q <= 4'h0;
            end else if (!cpu_req) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int N = dma_pkg::NUM_CHANNELS;
    logic                              clk, reset, desc_wr_en, fair_en, cpu_want, cpu_req, bus_done;
    logic [dma_pkg::DESC_W-1:0]        desc_wr_index;
    dma_pkg::transfer_descriptor_t     desc_wr_data;
    logic [N-1:0]                      ch_enable, ch_no_rotate, ch_trig_by_chan, hw_trig, sw_trig, ch_cancel;
    logic [N-1:0]                      ch_busy, ch_desc_done, ch_irq_start, ch_irq_done;
    logic [N-1:0][dma_pkg::DESC_W-1:0] ch_first_desc;
    logic [N-1:0][2:0]                 ch_level;
    logic [N-1:0][dma_pkg::CH_W-1:0]   ch_trig_src;
    logic [3:0]                        wait_cycles;
    dma_pkg::bus_req_t                 bus_req;
    dma_pkg::bus_req_t                 grants[$];
    int                                mismatches = 0, comparisons = 0, cycles = 0, nb, fl, first;

    dma_controller dut (.clk, .reset, .desc_wr_en, .desc_wr_index, .desc_wr_data, .ch_enable, .ch_first_desc,
        .ch_level, .ch_no_rotate, .ch_irq_on_start(ch_enable), .ch_trig_src, .ch_trig_by_chan, .fair_en, .hw_trig,
        .sw_trig, .ch_stall('0), .ch_cancel, .cpu_req, .bus_done, .bus_req, .ch_busy, .ch_desc_done,
        .ch_irq_start, .ch_irq_done);
    hub_model hub (.clk, .reset, .bus_req, .bus_done, .cpu_want, .wait_cycles, .cpu_req);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ********************************************************************
    // Grant log and hang guard
    // ********************************************************************
    always @(posedge clk) begin
        if (!reset && bus_done && bus_req.valid) grants.push_back(bus_req);
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("ERROR at %0t: timeout got %0h expected %0h", $time, cycles, 0);
            give_verdict();
        end
    end

    // ********************************************************************
    // Helpers
    // ********************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_desc(input int idx, input logic [31:0] src, input int nxt, input logic link);
        desc_wr_en = 1'b1;
        desc_wr_index = idx[6:0];
        desc_wr_data = '{src_addr: src, dst_addr: src + 32'h00010000, length: 17'h00001,
            width: dma_pkg::WIDTH_8, next_desc: nxt[6:0], has_next: link, irq_on_done: 1'b1};
        step(1);
        desc_wr_en = 1'b0;
    endtask

    task automatic kick(input logic [N-1:0] m);
        sw_trig = m;
        step(1);
        sw_trig = '0;
    endtask

    task automatic wait_grants(input int n);
        for (int i = 0; i < 3000 && grants.size() < n; i++) step(1);
        check(grants.size() >= n, 32'h1);
    endtask

    task automatic stop();
        ch_cancel = '1;
        for (int i = 0; i < 64 && ch_busy != '0; i++) step(1);
        ch_cancel = '0;
        step(2);
        grants.delete();
        check(ch_busy, 32'h0);
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic s_reset();
        check(ch_busy, 32'h0);
        check(bus_req.valid, 32'h0);
        kick(24'h000200);
        step(10);
        check(ch_busy[9], 32'h0);
    endtask

    task automatic s_simple();
        wr_desc(0, 32'h20000100, 0, 1'b0);
        kick(24'h000001);
        wait_grants(1);
        check(grants[0].channel, 32'h0);
        check(grants[0].dst_addr, 32'h20010100);
        check(grants[0].width, dma_pkg::WIDTH_8);
        check(ch_desc_done[0], 32'h1);
        check(ch_irq_done[0], 32'h1);
        step(5);
        wr_desc(0, 32'h20000200, 0, 1'b0);
        kick(24'h000001);
        wait_grants(2);
        check(grants[1].src_addr, 32'h20000200);
        stop();
    endtask

    task automatic s_ring(input int k);
        for (int i = 0; i < k; i++) wr_desc(60 + i, 32'h30000000 + i * 16, 60 + (i + 1) % k, 1'b1);
        ch_first_desc[8] = 7'h3C;
        kick(24'h000100);
        wait_grants(2 * k + 1);
        for (int i = 0; i <= 2 * k; i++) check(grants[i].src_addr, 32'h30000000 + (i % k) * 16);
        stop();
    endtask

    task automatic s_duel(input int a, input int la, input int b, input int lb, input int n);
        wr_desc(40 + a, 32'h40000000 + a, 40 + a, 1'b1);
        wr_desc(40 + b, 32'h40000000 + b, 40 + b, 1'b1);
        ch_first_desc[a] = 7'(40 + a);
        ch_first_desc[b] = 7'(40 + b);
        ch_level[a] = la[2:0];
        ch_level[b] = lb[2:0];
        kick((N'(1) << a) | (N'(1) << b));
        wait_grants(n);
        nb = 0;
        fl = 0;
        first = int'(grants[0].channel);
        for (int i = 0; i < n; i++) begin
            if (grants[i].channel === b[4:0]) nb++;
            if (i > 0 && grants[i].channel !== grants[i - 1].channel) fl++;
        end
        stop();
    endtask

    task automatic s_trig();
        ch_trig_by_chan[7] = 1'b1;
        ch_trig_src[7] = 5'h06;
        wr_desc(50, 32'h50000000, 50, 1'b0);
        wr_desc(51, 32'h50000010, 51, 1'b0);
        ch_first_desc[6] = 7'h32;
        ch_first_desc[7] = 7'h33;
        cpu_want = 1'b1;
        hw_trig[6] = 1'b1;
        step(1);
        hw_trig[6] = 1'b0;
        step(20);
        cpu_want = 1'b0;
        wait_grants(2);
        check(grants[0].channel, 32'h6);
        check(grants[1].channel, 32'h7);
        ch_trig_by_chan = '0;
        stop();
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {desc_wr_index, desc_wr_data, wait_cycles, ch_first_desc, ch_trig_src} = '0;
        {desc_wr_en, fair_en, cpu_want, ch_no_rotate, ch_trig_by_chan, hw_trig, sw_trig, ch_cancel} = '0;
        ch_level = '1;
        ch_enable = 24'hFFFDFF;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        step(1);
        s_reset();
        s_simple();
        wait_cycles = 4'h2;
        for (int k = 1; k <= 3; k++) s_ring(k);
        wait_cycles = 4'h0;
        s_duel(3, 4, 4, 4, 8);
        check(first, 32'h3);
        check(fl, 32'h7);
        ch_no_rotate[4] = 1'b1;
        s_duel(3, 4, 4, 4, 8);
        check(nb, 32'h8);
        ch_no_rotate = '0;
        s_duel(1, 5, 2, 0, 8);
        check(nb, 32'h8);
        s_duel(1, 2, 2, 3, 16);
        check(nb, 32'h0);
        fair_en = 1'b1;
        s_duel(1, 2, 2, 3, 16);
        check(nb >= 3, 32'h1);
        s_duel(1, 7, 2, 0, 8);
        check(nb, 32'h8);
        fair_en = 1'b0;
        s_trig();
        give_verdict();
    end
endmodule
